// [design/wws_consts.svh]
// named offsets, field positions, reset values and timing for the window watchdog
// assumes a 50 MHz system clock and a classic wishbone register bus
`ifndef WWS_CONSTS_SVH
`define WWS_CONSTS_SVH
`define WWS_CLK_MHZ 50
`define WWS_TICK_NS 1000
`define WWS_TICK_CYC ((`WWS_TICK_NS * `WWS_CLK_MHZ + 999) / 1000)
`define WWS_TICK_W 6
`define WWS_CNT_W 32
`define WWS_ADR_STATUS 8'h00
`define WWS_ADR_MASK 8'h04
`define WWS_ADR_CTRL 8'h08
`define WWS_ADR_STATE 8'h0c
`define WWS_EV_W 3
`define WWS_EV_TIMEOUT 0
`define WWS_EV_EARLY 1
`define WWS_EV_RELEASE 2
`define WWS_CTRL_DIS 0
`define WWS_SEL_OFF 2'h3
`define WWS_SEL_R8 2'h0
`define WWS_SEL_R4 2'h1
`define WWS_TP_CAP 2'h0
`define WWS_TP_NC 2'h1
`define WWS_MASK_RST 3'h0
`define WWS_CTRL_RST 1'h0
`define WWS_ST_FAULT_BIT 0
`define WWS_ST_CODE_LSB 1
`define WWS_ST_KICK_BIT 3
`define WWS_ST_OFF_BIT 4
`endif

// [design/wws_pkg.sv]
// types shared by the window watchdog design
// constants live in wws_consts.svh
package wws_pkg;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WATCH = 2'b01,
    ST_FAULT = 2'b10
  } wws_state_type;

  typedef struct packed {
    logic off;
    logic [31:0] lower;
    logic [31:0] upper;
  } wws_cfg_type;

  typedef struct packed {
    logic release_ev;
    logic early;
    logic timeout;
  } wws_ev_type;
endpackage : wws_pkg

// [design/wws_top.sv]
// window watchdog with supervisor reset delay and a wishbone register file
// assumes all inputs synchronous to i_clock except the kick pin, which is synchronised here
// open-drain pins: output value is always low, oe_n low while the pin is pulled low
//
// Functional notes
// (R1) host must give a falling kick edge between lower and upper window bounds
// (R2) kick is ignored while reset or fault pin is low
// (R3) kick transitions have no effect while the watchdog is disabled
// (R4) a watchdog timeout pulls the fault output low
// (R5) fault output may assert only while the reset output is high
// (R6) fault output stays low for the reset delay, then releases
// (R7) fault output is undriven whenever reset output is low
// (R8) select pins can disable the watchdog
// (R9) host keeps the kick pin at a defined level even when disabled
// (R10) select pins plus timing pin choose window ratio, timeout, or disable
// (R11) when rail is valid, count reset delay then raise reset output
// (R12) early kick counts as timeout; valid kick restarts window from zero
// (R13) kick is synchronised before falling edge detection
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "wws_consts.svh"
module wws_top #(
  parameter logic [31:0] P_UPPER_CAP_US = 32'd62740,
  parameter logic [31:0] P_UPPER_NC_US = 32'd1600000,
  parameter logic [31:0] P_UPPER_PU_US = 32'd200000,
  parameter logic [31:0] P_RST_DELAY_US = 32'd200000
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_rail_ok,
  input wire logic i_watchdog_kick_input,
  input wire logic i_window_select_0,
  input wire logic i_window_select_1,
  input wire logic [1:0] i_watchdog_timing_pin,
  input wire logic i_reset_out_in,
  output logic o_reset_out_out,
  output logic o_reset_out_oe_n,
  input wire logic i_watchdog_fault_out_in,
  output logic o_watchdog_fault_out_out,
  output logic o_watchdog_fault_out_oe_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_irq
);

  // window ratio from the select pins, upper bound from the timing pin strap
  function automatic wws_pkg::wws_cfg_type window_cfg(input logic [1:0] sel,
                                                      input logic [1:0] tp);
    wws_pkg::wws_cfg_type c;
    c.off = (sel == `WWS_SEL_OFF); // [R8] [R10]
    case (tp)
      `WWS_TP_CAP: c.upper = P_UPPER_CAP_US;
      `WWS_TP_NC: c.upper = P_UPPER_NC_US;
      default: c.upper = P_UPPER_PU_US;
    endcase
    // select 10, and the off code, fall back to half the upper bound
    case (sel)
      `WWS_SEL_R8: c.lower = c.upper >> 3; // [R10]
      `WWS_SEL_R4: c.lower = c.upper >> 2;
      default: c.lower = c.upper >> 1;
    endcase
    return c;
  endfunction : window_cfg

  // exact match on the whole byte address, so aliases read as unmapped
  function automatic logic adr_hit(input logic [7:0] adr,
                                   input logic [7:0] offs);
    return (adr == offs);
  endfunction : adr_hit

  // software view of the window state machine
  function automatic logic [31:0] state_word(input logic off,
                                             input logic kick_lvl,
                                             input wws_pkg::wws_state_type st);
    logic [31:0] w;
    w = '0;
    w[`WWS_ST_FAULT_BIT] = (st == wws_pkg::ST_FAULT);
    w[`WWS_ST_CODE_LSB +: $bits(st)] = st;
    w[`WWS_ST_KICK_BIT] = kick_lvl;
    w[`WWS_ST_OFF_BIT] = off;
    return w;
  endfunction : state_word

  // register read view; unmapped offsets read as zero
  function automatic logic [31:0] reg_read(input logic [7:0] adr,
                                           input logic [`WWS_EV_W-1:0] st,
                                           input logic [`WWS_EV_W-1:0] mk,
                                           input logic dis,
                                           input logic [31:0] view);
    logic [31:0] w;
    w = '0;
    case (adr)
      `WWS_ADR_STATUS: w[`WWS_EV_W-1:0] = st;
      `WWS_ADR_MASK: w[`WWS_EV_W-1:0] = mk;
      `WWS_ADR_CTRL: w[`WWS_CTRL_DIS] = dis;
      `WWS_ADR_STATE: w = view;
      default: w = '0;
    endcase
    return w;
  endfunction : reg_read

  // kick synchroniser and edge detector
  // flops reset high, the idle level of the pin, so no false edge follows reset
  logic kick_meta;
  logic kick_sync;
  logic kick_prev;
  logic next_kick_meta;
  logic next_kick_sync;
  logic next_kick_prev;
  logic kick_fall;

  always_comb begin
    next_kick_meta = i_watchdog_kick_input;
    next_kick_sync = kick_meta; // [R13]
    next_kick_prev = kick_sync;
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      kick_meta <= 1'b1;
      kick_sync <= 1'b1;
      kick_prev <= 1'b1;
    end else begin
      kick_meta <= next_kick_meta;
      kick_sync <= next_kick_sync;
      kick_prev <= next_kick_prev;
    end
  end

  assign kick_fall = kick_prev & ~kick_sync; // [R13]

  // microsecond tick so the long counters stay in time units
  // free-running phase: every bound carries up to one tick of slack
  logic [`WWS_TICK_W-1:0] tick_cnt;
  logic [`WWS_TICK_W-1:0] next_tick_cnt;
  logic tick;

  always_comb begin
    tick = (tick_cnt == `WWS_TICK_W'(`WWS_TICK_CYC - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + `WWS_TICK_W'(1);
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // supervisor and window state machine
  wws_pkg::wws_state_type state;
  wws_pkg::wws_state_type next_state;
  logic [`WWS_CNT_W-1:0] cnt;
  logic [`WWS_CNT_W-1:0] next_cnt;
  logic sw_disable;
  wws_pkg::wws_cfg_type cfg;
  wws_pkg::wws_ev_type ev;
  logic wd_off;
  logic kick_seen;

  always_comb begin
    cfg = window_cfg({i_window_select_1, i_window_select_0}, i_watchdog_timing_pin);
    wd_off = cfg.off | sw_disable; // [R3] [R8]
    // pin levels are checked too, since other drivers may pull the lines low
    kick_seen = kick_fall & ~wd_off & i_reset_out_in & i_watchdog_fault_out_in; // [R2] [R3]
    next_state = state;
    next_cnt = cnt;
    ev = '0;
    case (state)
      wws_pkg::ST_HOLD: begin
        if (!i_rail_ok) begin
          next_cnt = '0;
        end else if (cnt >= P_RST_DELAY_US) begin
          next_state = wws_pkg::ST_WATCH; // [R11]
          next_cnt = '0;
          ev.release_ev = 1'b1;
        end else if (tick) begin
          next_cnt = cnt + `WWS_CNT_W'(1); // [R11]
        end
      end
      wws_pkg::ST_WATCH: begin
        if (!i_rail_ok) begin
          next_state = wws_pkg::ST_HOLD;
          next_cnt = '0;
        end else if (wd_off) begin
          next_cnt = '0;
        end else if (kick_seen && cnt < cfg.lower) begin
          next_state = wws_pkg::ST_FAULT; // [R12] [R4]
          next_cnt = '0;
          ev.early = 1'b1;
        end else if (kick_seen) begin
          next_cnt = '0; // [R12] [R1]
        end else if (cnt >= cfg.upper) begin
          next_state = wws_pkg::ST_FAULT; // [R1] [R4]
          next_cnt = '0;
          ev.timeout = 1'b1;
        end else if (tick) begin
          next_cnt = cnt + `WWS_CNT_W'(1);
        end
      end
      wws_pkg::ST_FAULT: begin
        if (!i_rail_ok) begin
          next_state = wws_pkg::ST_HOLD; // [R7]
          next_cnt = '0;
        end else if (cnt >= P_RST_DELAY_US) begin
          // the next window starts from zero once the hold ends
          next_state = wws_pkg::ST_WATCH; // [R6]
          next_cnt = '0;
        end else if (tick) begin
          next_cnt = cnt + `WWS_CNT_W'(1); // [R6]
        end
      end
      default: begin
        next_state = wws_pkg::ST_HOLD;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= wws_pkg::ST_HOLD;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // open-drain pins: only pull low, never drive high
  assign o_reset_out_out = 1'b0;
  assign o_reset_out_oe_n = (state != wws_pkg::ST_HOLD); // [R11]
  assign o_watchdog_fault_out_out = 1'b0;
  // fault is only pulled while reset is released, else left floating
  assign o_watchdog_fault_out_oe_n = ~(state == wws_pkg::ST_FAULT); // [R4] [R5] [R7]

  // wishbone register file with sticky events and mask
  // registered ack gives one wait state; writes land on the edge that
  // completes the transfer, so status, mask and irq change as the ack drops, one clock after it rises
  logic [`WWS_EV_W-1:0] status;
  logic [`WWS_EV_W-1:0] mask;
  logic [`WWS_EV_W-1:0] next_status;
  logic [`WWS_EV_W-1:0] next_mask;
  logic next_sw_disable;
  logic next_ack;
  logic [31:0] next_dat;
  logic wr;
  logic rd_req;
  logic wr_status;
  logic wr_mask;
  logic wr_ctrl;

  always_comb begin
    rd_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & i_wb_sel[0];
    wr_status = wr & adr_hit(i_wb_adr, `WWS_ADR_STATUS);
    wr_mask = wr & adr_hit(i_wb_adr, `WWS_ADR_MASK);
    wr_ctrl = wr & adr_hit(i_wb_adr, `WWS_ADR_CTRL);
    next_ack = rd_req;
    next_status = status;
    next_mask = mask;
    next_sw_disable = sw_disable;
    next_dat = o_wb_dat;
    if (wr_status) begin
      next_status = status & ~i_wb_dat[`WWS_EV_W-1:0];
    end
    if (wr_mask) begin
      next_mask = i_wb_dat[`WWS_EV_W-1:0];
    end
    if (wr_ctrl) begin
      next_sw_disable = i_wb_dat[`WWS_CTRL_DIS];
    end
    // a new event wins over a clear in the same cycle
    next_status = next_status | ev;
    if (rd_req && !i_wb_we) begin
      next_dat = reg_read(i_wb_adr, status, mask, sw_disable,
                          state_word(wd_off, kick_sync, state));
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      status <= '0;
      mask <= `WWS_MASK_RST;
      sw_disable <= `WWS_CTRL_RST;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      sw_disable <= next_sw_disable;
      o_wb_ack <= next_ack;
      o_wb_dat <= next_dat;
    end
  end

  assign o_irq = |(status & mask);

endmodule : wws_top

// [verif/wws_host_model.sv]
// host side: kicks the watchdog pin with one falling edge per period
// assumes the bench holds i_en low whenever no kicks are wanted
`timescale 1ns/1ps
module wws_host_model (
  input wire logic i_clock,
  input wire logic i_en,
  input wire logic [15:0] i_period,
  output logic o_kick
);
  logic [15:0] cnt = 16'h0;
  initial o_kick = 1'h1; // pin always at a defined level
  always @(posedge i_clock) begin
    if (!i_en) begin
      cnt <= 16'h0;
      o_kick <= 1'h1;
    end else if (cnt == i_period) begin
      cnt <= 16'h0;
      o_kick <= 1'h0; // one falling edge per period
    end else begin
      cnt <= cnt + 16'h1;
      if (cnt == (i_period >> 1)) o_kick <= 1'h1;
    end
  end
endmodule : wws_host_model

// [verif/wws_props.sv]
// port-level checks for the window watchdog top
// assumes one clock and a 50-cycle tick per microsecond
`timescale 1ns/1ps
module wws_props #(
  parameter logic [31:0] P_RST_DELAY_US = 32'd200000
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_rail_ok,
  input wire logic i_window_select_0,
  input wire logic i_window_select_1,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic o_reset_out_oe_n,
  input wire logic o_watchdog_fault_out_oe_n,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack
);
  // tick phase is free running, so allow one tick below and two ticks above
  localparam int LO = (int'(P_RST_DELAY_US) - 1) * 50;
  localparam int HI = (int'(P_RST_DELAY_US) + 2) * 50;
  int fcnt;
  int rcnt;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      fcnt <= 0;
      rcnt <= 0;
    end else begin
      fcnt <= o_watchdog_fault_out_oe_n ? 0 : fcnt + 1;
      rcnt <= i_rail_ok ? rcnt + 1 : 0;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_bad_read;
    s_req ##0 (!i_wb_we && i_wb_adr == 8'h10);
  endsequence
  a_fault_needs_reset: assert property (
    !o_watchdog_fault_out_oe_n |-> o_reset_out_oe_n) else $error("fault while reset low");
  a_rail_loss_hold: assert property (
    !i_rail_ok |=> !o_reset_out_oe_n && o_watchdog_fault_out_oe_n) else $error("rail loss");
  a_disabled_quiet: assert property (
    i_window_select_0 && i_window_select_1 && $past(i_window_select_0)
    && $past(i_window_select_1) |-> !$fell(o_watchdog_fault_out_oe_n))
    else $error("fault while disabled");
  a_fault_hold: assert property (
    $rose(o_watchdog_fault_out_oe_n) && $past(i_rail_ok) |-> fcnt >= LO && fcnt <= HI)
    else $error("fault hold length wrong");
  a_reset_delay: assert property (
    $rose(o_reset_out_oe_n) |-> rcnt >= LO) else $error("reset released early");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_next: assert property (s_req |=> o_wb_ack) else $error("ack missing");
  a_unmapped_zero: assert property (s_bad_read |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
endmodule : wws_props
bind wws_top wws_props #(.P_RST_DELAY_US(P_RST_DELAY_US)) wws_props_i (.i_clock, .i_nrst,
  .i_rail_ok, .i_window_select_0, .i_window_select_1, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .i_wb_adr, .o_reset_out_oe_n, .o_watchdog_fault_out_oe_n, .o_wb_dat, .o_wb_ack);

// [verif/tb_wws_top.sv]
// bench: host model kicks, wishbone reads queue their expected words
// assumes pull-ups on both open-drain pins, so pin level equals oe_n
`timescale 1ns/1ps
`include "wws_consts.svh"
module tb_wws_top;
  logic clk;
  logic nrst = 1'h0, rail = 1'h1, s0 = 1'h0, s1 = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic en = 1'h0, kick, ack, ro, fo, irq, rv, fv;
  logic [1:0] tp = 2'h0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  logic [15:0] per = 16'h5dc;
  int errors = 0, samples_checked = 0;
  logic [31:0] eq[$], mq[$];
  wws_top #(.P_UPPER_CAP_US(32'd40), .P_UPPER_NC_US(32'd40), .P_UPPER_PU_US(32'd40),
    .P_RST_DELAY_US(32'd20)) wws_top_i (.i_clock(clk), .i_nrst(nrst), .i_rail_ok(rail),
    .i_watchdog_kick_input(kick), .i_window_select_0(s0), .i_window_select_1(s1),
    .i_watchdog_timing_pin(tp), .i_reset_out_in(ro), .o_reset_out_out(rv), .o_reset_out_oe_n(ro),
    .i_watchdog_fault_out_in(fo), .o_watchdog_fault_out_out(fv), .o_watchdog_fault_out_oe_n(fo),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(dat), .o_wb_dat(rd), .o_wb_ack(ack), .o_irq(irq));
  wws_host_model wws_host_model_i (.i_clock(clk), .i_en(en), .i_period(per), .o_kick(kick));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // for reads d is the expected word, compared under mask m when ack arrives
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [31:0] m);
    @(posedge clk);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dat <= d; sel <= s;
    if (!w) begin
      eq.push_back(d);
      mq.push_back(m);
    end
    do @(posedge clk); while (ack !== 1'h1);
    cyc <= 1'h0; stb <= 1'h0;
  endtask : wb
  task automatic wt(input bit r, input logic v, input int n);
    repeat (n) begin
      @(posedge clk);
      if ((r ? ro : fo) === v) break;
    end
    chk(r ? "reset_pin" : "fault_pin", {31'h0, r ? ro : fo}, {31'h0, v});
  endtask : wt
  always @(posedge clk) begin
    if (ack === 1'h1 && !we && eq.size() > 0) begin
      chk("rdata", rd & mq[0], eq[0] & mq[0]); // register views
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(27444));
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    tp <= 2'($urandom % 4);
    wt(1, 1'h1, 1100); // delay then release
    wb(0, `WWS_ADR_STATE, 32'ha, 4'hf, 32'h1f); // watching
    wb(0, `WWS_ADR_STATUS, 32'h4, 4'hf, 32'h7); // release event
    wb(1, `WWS_ADR_MASK, 32'h7, 4'h0, 32'h0);
    wb(0, `WWS_ADR_MASK, 32'h0, 4'hf, 32'h7);
    wb(1, `WWS_ADR_MASK, 32'h7, 4'hf, 32'h0);
    wb(1, `WWS_ADR_STATUS, 32'h7, 4'hf, 32'h0);
    wb(0, 8'h10, 32'h0, 4'hf, 32'hffffffff);
    {s1, s0} <= 2'($urandom % 3);
    per <= 16'(1200 + $urandom % 600);
    en <= 1'h1;
    repeat (6000) @(posedge clk);
    wb(0, `WWS_ADR_STATUS, 32'h0, 4'hf, 32'h3); // kicks in window
    en <= 1'h0;
    wt(0, 1'h0, 2200); // no kick times out
    chk("irq", {31'h0, irq}, 32'h1); // raised when unmasked
    wb(1, `WWS_ADR_STATUS, 32'h7, 4'hf, 32'h0);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0); // cleared by W1C
    {s1, s0} <= 2'h0;
    per <= 16'h64;
    en <= 1'h1;
    repeat (500) @(posedge clk);
    wb(0, `WWS_ADR_STATUS, 32'h0, 4'hf, 32'h3); // kicks during fault ignored
    wb(1, `WWS_ADR_MASK, 32'h0, 4'hf, 32'h0);
    wt(0, 1'h1, 700); // fault released
    wt(0, 1'h0, 300); // early kick faults
    wb(0, `WWS_ADR_STATUS, 32'h2, 4'hf, 32'h2); // early flag
    chk("irq", {31'h0, irq}, 32'h0); // masked out
    rail <= 1'h0;
    {s1, s0} <= 2'h3;
    repeat (2) @(posedge clk);
    chk("fault_pin", {31'h0, fo}, 32'h1); // undriven in reset
    chk("reset_pin", {31'h0, ro}, 32'h0); // reset asserted
    rail <= 1'h1;
    wt(1, 1'h1, 1100); // release again
    repeat (3000) @(posedge clk);
    chk("fault_pin", {31'h0, fo}, 32'h1); // early kicks ignored when off
    wb(0, `WWS_ADR_STATE, 32'h10, 4'hf, 32'h10); // disabled flag
    wb(1, `WWS_ADR_CTRL, 32'h1, 4'hf, 32'h0);
    {s1, s0} <= 2'h0;
    repeat (400) @(posedge clk);
    chk("fault_pin", {31'h0, fo}, 32'h1); // software disable ignores early kicks
    wb(0, `WWS_ADR_CTRL, 32'h1, 4'hf, 32'h1); // software disable readback
    wb(0, `WWS_ADR_STATE, 32'h12, 4'hf, 32'h17); // off while watching
    chk("pin_values", {30'h0, rv, fv}, 32'h0); // open-drain pins only pull low
    wrap_up();
  end
endmodule : tb_wws_top
